// ==== core/card_seq_pkg.sv ====
// Purpose: Shared constants and types for the card session sequencer and its host end.
// Assumes: Both ends run on a 10 MHz core clock.
// Notes: Interval defaults are plain values; override through the module parameters.
package card_seq_pkg;

	// -----------------------------------------------------------------
	// Clock and timing constants
	// -----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100; // Core clock period.
	localparam int POWERUP_WINDOW_MS = 10; // Activation lockout after supply is good.
	localparam int POWERUP_CYCLES = (POWERUP_WINDOW_MS * 1000000) / CLK_PERIOD_NS;
	localparam int STEP_US = 100; // Default length of each sequence interval.
	localparam int STEP_CYCLES = (STEP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CHAR_TIME_US = 4000; // Longest legal low time of the host data line.
	localparam int CHAR_CYCLES = (CHAR_TIME_US * 1000) / CLK_PERIOD_NS;
	localparam int RESTART_US = 200; // Gap the host leaves before requesting a session again.
	localparam int RESTART_CYCLES = (RESTART_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 20; // Width of every interval counter.

	// -----------------------------------------------------------------
	// Card clock ratio select codes {sel_a, sel_b}
	// -----------------------------------------------------------------
	localparam logic [1:0] RATIO_DIV6 = 2'h0;
	localparam logic [1:0] RATIO_DIV4 = 2'h1;
	localparam logic [1:0] RATIO_DIV1 = 2'h2;
	localparam logic [1:0] RATIO_DIV2 = 2'h3;
	localparam logic [1:0] HALF_DIV6 = 2'h2; // Toggle after this count plus one.
	localparam logic [1:0] HALF_DIV4 = 2'h1;
	localparam logic [1:0] HALF_DIV2 = 2'h0;

	// -----------------------------------------------------------------
	// Host register map (byte addresses) and fields
	// -----------------------------------------------------------------
	localparam logic [2:0] ADDR_CTRL = 3'h0;
	localparam logic [2:0] ADDR_STATUS = 3'h4;
	localparam int CTRL_SESSION = 0;
	localparam int CTRL_CARD_RST = 1;
	localparam int CTRL_SEL_A = 2;
	localparam int CTRL_SEL_B = 3;
	localparam int CTRL_SUPPLY_5V = 4;
	localparam int CTRL_IO_LOW = 5;
	localparam int CTRL_W = 6;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h1c;
	localparam int STAT_LINE = 0;
	localparam int STAT_IO = 1;
	localparam int STAT_STUCK = 2;

	// -----------------------------------------------------------------
	// Sequencer and data steering states
	// -----------------------------------------------------------------
	typedef enum logic [10:0] {
		S_IDLE = 11'h001,
		S_RAMP = 11'h002,
		S_IO_ON = 11'h004,
		S_CLK_ON = 11'h008,
		S_WAIT_RST = 11'h010,
		S_ACTIVE = 11'h020,
		S_D_RST = 11'h040,
		S_D_CLK = 11'h080,
		S_D_IO = 11'h100,
		S_D_VCC = 11'h200,
		S_DISCH = 11'h400
	} seq_state_e;

	typedef enum logic [3:0] {
		IO_NEUTRAL = 4'h1,
		IO_HOST_IN = 4'h2,
		IO_CARD_IN = 4'h4,
		IO_BOTH = 4'h8
	} io_state_e;

endpackage : card_seq_pkg

// ==== core/card_link_if.sv ====
// Purpose: Pins between the host controller and the card session sequencer.
// Assumes: Open-drain lines have a pull-up; either end pulls low with its enable.
// Notes: Resolved line levels are worked out here from the enables.
`timescale 1ns/1ps
interface card_link_if;
	logic session_request_n; // Host opens a session by driving low.
	logic card_reset_request; // Host wish for the card reset level.
	logic clock_ratio_sel_a; // Card clock ratio select, first bit.
	logic clock_ratio_sel_b; // Card clock ratio select, second bit.
	logic supply_level_select; // High selects 5 V, low 3 V.
	logic status_out; // Device status line drive value.
	logic status_oe; // Device pulls status line.
	logic status_n; // Resolved status line.
	logic dev_io_out; // Device drive value on host data line.
	logic dev_io_oe; // Device drives host data line.
	logic host_io_out; // Host drive value on host data line.
	logic host_io_oe; // Host drives host data line.
	logic host_side_io; // Resolved host data line.

	// Pulled-up wires: low whenever an enabled driver drives low.
	assign status_n = ~(status_oe & ~status_out);
	assign host_side_io = ~((dev_io_oe & ~dev_io_out) | (host_io_oe & ~host_io_out));

	modport dev (
		input session_request_n, card_reset_request, clock_ratio_sel_a,
		input clock_ratio_sel_b, supply_level_select, host_side_io,
		output status_out, status_oe, dev_io_out, dev_io_oe
	);
	modport host (
		output session_request_n, card_reset_request, clock_ratio_sel_a,
		output clock_ratio_sel_b, supply_level_select, host_io_out, host_io_oe,
		input status_n, host_side_io
	);
endinterface : card_link_if

// ==== core/card_session_sequencer.sv ====
// Purpose: Card session sequencer: activation, deactivation, status line, data steering.
// Assumes: core_clk_i is the oscillator input; reset_i comes from power-on and supervisor.
// Notes: Card data line is open drain with a pull-up on the card side.
`timescale 1ns/1ps
module card_session_sequencer
	import card_seq_pkg::*;
#(
	parameter int POWERUP_CNT = POWERUP_CYCLES,
	parameter int T1_CNT = STEP_CYCLES,
	parameter int T2_CNT = STEP_CYCLES,
	parameter int T3_CNT = STEP_CYCLES,
	parameter int T4_CNT = STEP_CYCLES,
	parameter int T5_CNT = STEP_CYCLES
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic reset_i,
	// Host side pins
	card_link_if.dev link,
	// Card contacts and analog status
	input wire logic card_detect_i,
	input wire logic overcurrent_i,
	input wire logic card_supply_valid_i,
	input wire logic logic_supply_fault_level_i,
	output logic card_supply_en_o,
	output logic card_supply_5v_o,
	output logic card_clk_o,
	output logic card_rst_o,
	input wire logic card_io_i,
	output logic card_io_o,
	output logic card_io_oe_o
);

	// -----------------------------------------------------------------
	// Input synchronisers
	// -----------------------------------------------------------------
	localparam int NSYNC = 11;
	logic [NSYNC-1:0] sync_raw; // Raw asynchronous inputs.
	logic [NSYNC-1:0] sync_a; // First stage, read only by the second.
	logic [NSYNC-1:0] sync_b; // Second stage, safe to use.
	assign sync_raw = {link.session_request_n, link.card_reset_request, link.clock_ratio_sel_a,
		link.clock_ratio_sel_b, link.supply_level_select, link.host_side_io, card_detect_i,
		overcurrent_i, card_supply_valid_i, logic_supply_fault_level_i, card_io_i};

	// Two flops per pin, laid down by one loop.
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++)
		begin : g_sync
			always_ff @(posedge core_clk_i or posedge reset_i)
			begin
				if (reset_i)
				begin
					sync_a[gi] <= 1'b0;
					sync_b[gi] <= 1'b0;
				end
				else
				begin
					sync_a[gi] <= sync_raw[gi];
					sync_b[gi] <= sync_a[gi];
				end
			end
		end
	endgenerate

	logic req_n, rst_req, sel_a, sel_b, lvl_5v, host_io, present, ovc, vcc_ok, vdd_flt, card_io;
	assign {req_n, rst_req, sel_a, sel_b, lvl_5v, host_io, present, ovc, vcc_ok, vdd_flt,
		card_io} = sync_b;

	// Previous values for edge detection.
	logic req_n_q, rst_req_q, host_io_q, card_io_q;
	logic primed; // Edge history valid after first sample.
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			{req_n_q, rst_req_q, host_io_q, card_io_q, primed} <= 5'h00;
		end
		else
		begin
			{req_n_q, rst_req_q, host_io_q, card_io_q, primed} <=
				{req_n, rst_req, host_io, card_io, 1'b1};
		end
	end
	logic req_fall, rst_fall, host_fall, host_rise, card_fall, card_rise;
	assign req_fall = primed & req_n_q & ~req_n;
	assign rst_fall = primed & rst_req_q & ~rst_req;
	assign host_fall = primed & host_io_q & ~host_io;
	assign host_rise = primed & ~host_io_q & host_io;
	assign card_fall = primed & card_io_q & ~card_io;
	assign card_rise = primed & ~card_io_q & card_io;

	// -----------------------------------------------------------------
	// Power-up lockout
	// -----------------------------------------------------------------
	logic [CNT_W-1:0] pwr_cnt; // Counts good-supply cycles.
	logic pwr_ready; // Lockout window elapsed.
	// A supply fault restarts the window, so activation waits again after a dip.
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			pwr_cnt <= '0;
			pwr_ready <= 1'b0;
		end
		else if (vdd_flt)
		begin
			pwr_cnt <= '0;
			pwr_ready <= 1'b0;
		end
		else if (pwr_cnt >= CNT_W'(POWERUP_CNT - 1))
		begin
			pwr_ready <= 1'b1;
		end
		else
		begin
			pwr_cnt <= pwr_cnt + 1'b1;
		end
	end

	// -----------------------------------------------------------------
	// Sequencer
	// -----------------------------------------------------------------
	seq_state_e state, next_state; // Session sequencer state.
	logic [CNT_W-1:0] cnt; // Interval counter, restarts on each state change.
	logic cnt_done; // Current interval elapsed.
	logic rst_mode; // Reset request was high at activation.
	logic fault_flag; // Session fault reported on the status line.
	logic in_session, session_fault;
	logic [CNT_W-1:0] limit;

	assign in_session = (state == S_RAMP) || (state == S_IO_ON) || (state == S_CLK_ON) ||
		(state == S_WAIT_RST) || (state == S_ACTIVE);
	// Card supply is only checked once the ramp interval has passed.
	assign session_fault = in_session && (ovc || vdd_flt || !present ||
		(state != S_RAMP && !vcc_ok));

	// Interval length of each timed state.
	always_comb
	begin
		limit = '0;
		case (state)
			S_RAMP: limit = CNT_W'(T1_CNT);
			S_IO_ON: limit = CNT_W'(T2_CNT);
			S_CLK_ON: limit = CNT_W'(T3_CNT);
			S_D_RST: limit = CNT_W'(T1_CNT);
			S_D_CLK: limit = CNT_W'(T2_CNT);
			S_D_IO: limit = CNT_W'(T3_CNT);
			S_D_VCC: limit = CNT_W'(T4_CNT);
			S_DISCH: limit = CNT_W'(T5_CNT);
			default: limit = '0;
		endcase
	end
	assign cnt_done = (cnt >= limit - 1'b1);

	// Next state: faults and host release take priority over stepping.
	always_comb
	begin
		next_state = state;
		case (state)
			S_IDLE:
				if (req_fall && pwr_ready && present && !vdd_flt)
					next_state = S_RAMP;
			S_RAMP:
				if (session_fault || req_n)
					next_state = S_D_RST;
				else if (cnt_done && !vcc_ok)
					next_state = S_DISCH;
				else if (cnt_done)
					next_state = rst_mode ? S_WAIT_RST : S_IO_ON;
			S_IO_ON, S_CLK_ON:
				if (session_fault || req_n)
					next_state = S_D_RST;
				else if (cnt_done)
					next_state = (state == S_IO_ON) ? S_CLK_ON : S_ACTIVE;
			S_WAIT_RST:
				if (session_fault || req_n)
					next_state = S_D_RST;
				else if (rst_fall)
					next_state = S_ACTIVE;
			S_ACTIVE:
				if (session_fault || req_n)
					next_state = S_D_RST;
			S_D_RST: if (cnt_done) next_state = S_D_CLK;
			S_D_CLK: if (cnt_done) next_state = S_D_IO;
			S_D_IO: if (cnt_done) next_state = S_D_VCC;
			S_D_VCC: if (cnt_done) next_state = S_DISCH;
			S_DISCH: if (cnt_done) next_state = S_IDLE;
			default: next_state = S_IDLE;
		endcase
	end

	// State register and interval counter.
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			state <= S_IDLE;
			cnt <= '0;
		end
		else
		begin
			state <= next_state;
			cnt <= (next_state != state) ? '0 : cnt + 1'b1;
		end
	end

	// Reset mode is captured at the activating edge.
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
			rst_mode <= 1'b0;
		else if (state == S_IDLE && next_state == S_RAMP)
			rst_mode <= rst_req;
	end

	// Fault flag sets on a session fault and clears only once the host ends the request.
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
			fault_flag <= 1'b0;
		else if (session_fault || (state == S_RAMP && cnt_done && !vcc_ok))
			fault_flag <= 1'b1;
		else if (state == S_IDLE && req_n)
			fault_flag <= 1'b0;
	end

	// -----------------------------------------------------------------
	// Card control outputs
	// -----------------------------------------------------------------
	logic io_rx_en, clk_run;
	// Fault report is combinational so the status line falls with the deactivation start.
	assign link.status_out = 1'b0;
	assign link.status_oe = session_fault || fault_flag ||
		(state == S_IDLE && !present);
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			card_supply_en_o <= 1'b0;
			card_supply_5v_o <= 1'b0;
			io_rx_en <= 1'b0;
			clk_run <= 1'b0;
			card_rst_o <= 1'b0;
		end
		else
		begin
			card_supply_en_o <= (next_state != S_IDLE) && (next_state != S_DISCH);
			if (state == S_IDLE)
				card_supply_5v_o <= lvl_5v;
			io_rx_en <= (next_state == S_CLK_ON) || (next_state == S_ACTIVE) ||
				(next_state == S_D_RST) || (next_state == S_D_CLK) ||
				(next_state == S_IO_ON && !rst_mode);
			clk_run <= (next_state == S_CLK_ON) || (next_state == S_ACTIVE) ||
				(next_state == S_D_RST);
			card_rst_o <= (next_state == S_ACTIVE) ? rst_req : 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// Card clock divider
	// -----------------------------------------------------------------
	logic [1:0] ratio, div_cnt, half;
	logic div_clk; // Divided card clock.
	assign ratio = {sel_a, sel_b};
	assign half = (ratio == RATIO_DIV6) ? HALF_DIV6 : (ratio == RATIO_DIV4) ? HALF_DIV4 : HALF_DIV2;
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			div_cnt <= '0;
			div_clk <= 1'b0;
		end
		else if (!clk_run)
		begin
			div_cnt <= '0;
			div_clk <= 1'b0;
		end
		else if (div_cnt >= half)
		begin
			div_cnt <= '0;
			div_clk <= ~div_clk;
		end
		else
		begin
			div_cnt <= div_cnt + 1'b1;
		end
	end
	// Undivided mode gates the oscillator itself; it is fit only for inputs up to 20 MHz.
	assign card_clk_o = (ratio == RATIO_DIV1) ? (core_clk_i & clk_run) : div_clk;

	// -----------------------------------------------------------------
	// Data line steering
	// -----------------------------------------------------------------
	io_state_e io_state; // Which line is currently the input.
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
			io_state <= IO_NEUTRAL;
		else if (!io_rx_en)
			io_state <= IO_NEUTRAL;
		else
			case (io_state)
				IO_NEUTRAL:
					if (host_fall && card_fall)
						io_state <= IO_BOTH;
					else if (host_fall)
						io_state <= IO_HOST_IN;
					else if (card_fall)
						io_state <= IO_CARD_IN;
				IO_HOST_IN: if (host_rise) io_state <= IO_NEUTRAL;
				IO_CARD_IN: if (card_rise) io_state <= IO_NEUTRAL;
				IO_BOTH: if (host_io || card_io) io_state <= IO_NEUTRAL;
				default: io_state <= IO_NEUTRAL;
			endcase
	end

	// Open-drain drives: only a low is ever driven, so a release lets the far end win.
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			card_io_oe_o <= 1'b1;
			link.dev_io_oe <= 1'b0;
		end
		else
		begin
			card_io_oe_o <= !io_rx_en || (io_state == IO_BOTH) ||
				(io_state == IO_HOST_IN && !host_io);
			link.dev_io_oe <= io_rx_en && ((io_state == IO_BOTH) ||
				(io_state == IO_CARD_IN && !card_io));
		end
	end
	assign card_io_o = 1'b0;
	assign link.dev_io_out = 1'b0;

endmodule : card_session_sequencer

// ==== core/card_host_ctrl.sv ====
// Purpose: Host end: drives the request pins from registers reached over Avalon-MM.
// Assumes: Registers at byte addresses 0x0 (control) and 0x4 (status).
// Notes: An overlong low data line ends the session; the request returns after the restart gap, reopening it only if the gap outlasts deactivation.
`timescale 1ns/1ps
module card_host_ctrl
	import card_seq_pkg::*;
#(
	parameter int CHAR_CNT = CHAR_CYCLES,
	parameter int RESTART_CNT = RESTART_CYCLES
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic reset_i,
	// Avalon-MM slave
	input wire logic [2:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Device pins
	card_link_if.host link
);

	// -----------------------------------------------------------------
	// Synchronisers for the device lines
	// -----------------------------------------------------------------
	logic [1:0] sync_a, sync_b; // {status, data line}; first stage read only by second.
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			sync_a <= 2'h3;
			sync_b <= 2'h3;
		end
		else
		begin
			sync_a <= {link.status_n, link.host_side_io};
			sync_b <= sync_a;
		end
	end

	// -----------------------------------------------------------------
	// Bus slave: one wait cycle, then the answer
	// -----------------------------------------------------------------
	logic ack; // High in the cycle the access completes.
	logic [CTRL_W-1:0] ctrl; // Control register.
	logic stuck; // Sticky overlong-low flag.
	logic stuck_set;
	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack;
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
			ack <= 1'b0;
		else
			ack <= (avs_read_i || avs_write_i) && !ack;
	end

	// Control register write.
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
			ctrl <= CTRL_RESET;
		else if (avs_write_i && ack && avs_address_i == ADDR_CTRL)
			ctrl <= avs_writedata_i[CTRL_W-1:0];
	end

	// Read data; unmapped addresses read zero.
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
			avs_readdata_o <= '0;
		else if (avs_address_i == ADDR_CTRL)
			avs_readdata_o <= {{(32-CTRL_W){1'b0}}, ctrl};
		else if (avs_address_i == ADDR_STATUS)
			avs_readdata_o <= {29'h0, stuck, sync_b[0], sync_b[1]};
		else
			avs_readdata_o <= '0;
	end

	// -----------------------------------------------------------------
	// Overlong low watch and automatic restart
	// -----------------------------------------------------------------
	logic [CNT_W-1:0] low_cnt; // Cycles the data line has stayed low.
	logic [CNT_W-1:0] gap_cnt; // Remaining forced-release cycles.
	assign stuck_set = ctrl[CTRL_SESSION] && gap_cnt == '0 && !sync_b[0] &&
		low_cnt >= CNT_W'(CHAR_CNT - 1);
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			low_cnt <= '0;
			gap_cnt <= '0;
		end
		else if (stuck_set)
		begin
			low_cnt <= '0;
			gap_cnt <= CNT_W'(RESTART_CNT);
		end
		else
		begin
			low_cnt <= sync_b[0] ? '0 : low_cnt + 1'b1;
			if (gap_cnt != '0)
				gap_cnt <= gap_cnt - 1'b1;
		end
	end

	// Sticky flag: a new event wins over a write-one clear in the same cycle.
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
			stuck <= 1'b0;
		else if (stuck_set)
			stuck <= 1'b1;
		else if (avs_write_i && ack && avs_address_i == ADDR_STATUS &&
			avs_writedata_i[STAT_STUCK])
			stuck <= 1'b0;
	end

	// -----------------------------------------------------------------
	// Pin drives from flops; host data drive value tied low
	// -----------------------------------------------------------------
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			link.session_request_n <= 1'b1;
			link.card_reset_request <= 1'b0;
			link.clock_ratio_sel_a <= 1'b0;
			link.clock_ratio_sel_b <= 1'b0;
			link.supply_level_select <= 1'b0;
			link.host_io_oe <= 1'b0;
		end
		else
		begin
			// Session held open only outside a restart gap.
			link.session_request_n <= !(ctrl[CTRL_SESSION] && gap_cnt == '0 && !stuck_set);
			link.card_reset_request <= ctrl[CTRL_CARD_RST];
			link.clock_ratio_sel_a <= ctrl[CTRL_SEL_A];
			link.clock_ratio_sel_b <= ctrl[CTRL_SEL_B];
			link.supply_level_select <= ctrl[CTRL_SUPPLY_5V];
			link.host_io_oe <= ctrl[CTRL_IO_LOW];
		end
	end
	assign link.host_io_out = 1'b0;

endmodule : card_host_ctrl

// ==== dv/card_seq_props.sv ====
// Purpose: Concurrent checks on the sequencer pins beside the link.
// Assumes: Bench intervals of 6 cycles, discharge of 4.
// Notes: Windows allow for the two-flop input synchronisers.
`timescale 1ns/1ps
module card_seq_props (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic reset_i,
	// Link pins
	input wire logic session_request_n,
	input wire logic card_reset_request,
	input wire logic status_n,
	// Card side pins
	input wire logic card_detect_i,
	input wire logic overcurrent_i,
	input wire logic card_supply_en_o,
	input wire logic card_clk_o,
	input wire logic card_rst_o,
	input wire logic card_io_oe_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	// Deactivation steps: reset drops first, the supply four intervals later.
	sequence rst_drop_s;
		##[1:8] (!card_rst_o && card_supply_en_o);
	endsequence
	sequence vcc_drop_s;
		##[17:29] !card_supply_en_o;
	endsequence
	deact_order_a: assert property ($rose(session_request_n) && card_rst_o |->
		rst_drop_s ##1 vcc_drop_s) else $error("deactivation order broken");
	supply_off_a: assert property (!card_supply_en_o |-> !card_rst_o && !card_clk_o)
		else $error("card reset or clock live without supply");
	io_idle_a: assert property (!card_supply_en_o |-> card_io_oe_o)
		else $error("card data released without supply");
	start_gate_a: assert property ($rose(card_supply_en_o) |-> card_detect_i)
		else $error("supply raised without card");
	rst_cause_a: assert property ($rose(card_rst_o) |-> card_reset_request)
		else $error("card reset rose without request");
	fault_line_a: assert property ($rose(overcurrent_i) && card_supply_en_o
		&& !session_request_n |-> ##[1:5] !status_n) else $error("fault not reported");
	absent_line_a: assert property ((!card_detect_i && session_request_n)[*4]
		|-> !status_n) else $error("status high without card");
	present_line_a: assert property ((card_detect_i && session_request_n
		&& !card_supply_en_o)[*8] |-> status_n) else $error("status low with card idle");
endmodule : card_seq_props

// ==== dv/smart_card_session_sequencer_tb_top.sv ====
// Purpose: Bench joining the host end and the card sequencer over their link.
// Assumes: Intervals of 6 cycles, discharge of 4, lockout of 50 cycles.
// Notes: Card data line is open drain, pulled up.
`timescale 1ns/1ps
module smart_card_session_sequencer_tb_top;
	import card_seq_pkg::*;
	localparam int T = 6; // Interval t1 to t4 in cycles.
	logic clk = 1'b0, rst = 1'b1, card_det = 1'b0, oc = 1'b0, card_pull = 1'b0;
	logic av_r = 1'b0, av_w = 1'b0, av_wait, en, v5, cclk, crst, cio_oe;
	logic [2:0] av_a = 3'h0;
	logic [31:0] av_wd = 32'h0, av_rd, rd;
	wire cio = ~(cio_oe | card_pull); // Either side pulls the card data low.
	int n_mismatch = 0, tests_run = 0, n_clk = 0;
	int rises[4] = '{4, 6, 24, 12}; // Card clock rises in 24 cycles per ratio code.
	card_link_if link();
	card_host_ctrl #(.CHAR_CNT(200), .RESTART_CNT(20)) u_card_host_ctrl (.core_clk_i(clk),
		.reset_i(rst), .avs_address_i(av_a), .avs_read_i(av_r), .avs_write_i(av_w),
		.avs_writedata_i(av_wd), .avs_readdata_o(av_rd), .avs_waitrequest_o(av_wait), .link(link));
	card_session_sequencer #(.POWERUP_CNT(50), .T1_CNT(T), .T2_CNT(T), .T3_CNT(T), .T4_CNT(T),
		.T5_CNT(4)) u_card_session_sequencer (.core_clk_i(clk), .reset_i(rst), .link(link),
		.card_detect_i(card_det), .overcurrent_i(oc), .card_supply_valid_i(en),
		.logic_supply_fault_level_i(1'b0), .card_supply_en_o(en), .card_supply_5v_o(v5),
		.card_clk_o(cclk), .card_rst_o(crst), .card_io_i(cio), .card_io_o(), .card_io_oe_o(cio_oe));
	card_seq_props u_props (.core_clk_i(clk), .reset_i(rst), .status_n(link.status_n),
		.session_request_n(link.session_request_n), .card_reset_request(link.card_reset_request),
		.card_detect_i(card_det), .overcurrent_i(oc), .card_supply_en_o(en), .card_clk_o(cclk),
		.card_rst_o(crst), .card_io_oe_o(cio_oe));
	// Clock and card clock edge counter.
	initial
	begin
		forever #50 clk = ~clk;
	end
	always @(posedge cclk) n_clk++;
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
		end
	endtask : chk
	// Avalon access: hold the request until the rising edge that sees waitrequest low.
	// Read data is taken at that same edge, and only then is the request released.
	task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
		@(posedge clk);
		av_a <= a;
		av_wd <= d;
		av_w <= w;
		av_r <= !w;
		do @(posedge clk); while (av_wait !== 1'b0);
		rd = av_rd;
		av_w <= 1'b0;
		av_r <= 1'b0;
	endtask : bus
	// Counts card clock rises over 24 core cycles.
	task automatic meas(input int e);
		int c;
		@(negedge clk);
		c = n_clk;
		repeat (24) @(negedge clk);
		chk("card_clk", n_clk - c, e);
	endtask : meas
	task end_sim;
		$display("mismatches %0d checks %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim
	initial
	begin
		repeat (6000) @(posedge clk);
		n_mismatch++;
		end_sim();
	end
	initial
	begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		// Let the status line pass the host's two-flop synchroniser before reading it.
		repeat (4) @(posedge clk);
		bus(0, ADDR_STATUS, 0);
		chk("no_card", rd[0], 1'b0);
		card_det <= 1'b1;
		bus(1, ADDR_CTRL, 32'h1d);
		repeat (3 * T + 12) @(posedge clk);
		chk("lockout", en, 1'b0);
		repeat (30) @(posedge clk);
		chk("level", en, 1'b0);
		$display("lockout done");
		for (int i = 0; i < 4; i++)
		begin
			bus(1, ADDR_CTRL, 32'h1c);
			repeat (5 * T + 12) @(posedge clk);
			bus(1, ADDR_CTRL, {26'h0, 2'h1, i[0], i[1], 2'h1});
			repeat (3 * T + 12) @(posedge clk);
			meas(rises[i]);
			chk("rx_on", cio_oe, 1'b0);
			chk("v5", v5, 1'b1);
		end
		bus(1, ADDR_CTRL, 32'h1e);
		repeat (5 * T + 12) @(posedge clk);
		bus(1, ADDR_CTRL, 32'h1f);
		repeat (3 * T + 12) @(posedge clk);
		meas(0);
		chk("rx_wait", cio_oe, 1'b1);
		bus(1, ADDR_CTRL, 32'h1d);
		repeat (8) @(posedge clk);
		meas(12);
		bus(1, ADDR_CTRL, 32'h1f);
		repeat (6) @(posedge clk);
		chk("card_rst", crst, 1'b1);
		bus(1, ADDR_CTRL, 32'h1e);
		repeat (5 * T + 12) @(posedge clk);
		chk("off", en, 1'b0);
		$display("ratio and reset done");
		bus(1, ADDR_CTRL, 32'h1d);
		repeat (3 * T + 12) @(posedge clk);
		bus(1, ADDR_CTRL, 32'h3d);
		repeat (6) @(posedge clk);
		chk("card_out", cio_oe, 1'b1);
		bus(1, ADDR_CTRL, 32'h1d);
		repeat (6) @(posedge clk);
		chk("card_rel", cio_oe, 1'b0);
		card_pull <= 1'b1;
		repeat (6) @(posedge clk);
		bus(0, ADDR_STATUS, 0);
		chk("host_out", rd[1], 1'b0);
		card_pull <= 1'b0;
		repeat (6) @(posedge clk);
		chk("host_rel", link.host_side_io, 1'b1);
		oc <= 1'b1;
		repeat (6) @(posedge clk);
		chk("fault", link.status_n, 1'b0);
		repeat (5 * T + 12) @(posedge clk);
		chk("fault_off", en, 1'b0);
		bus(1, ADDR_CTRL, 32'h1c);
		repeat (10) @(posedge clk);
		chk("idle", link.status_n, 1'b1);
		oc <= 1'b0;
		$display("steering and fault done");
		end_sim();
	end
endmodule : smart_card_session_sequencer_tb_top
